// ===== design/interval_timer_pair.sv
`timescale 1ns/10ps
`default_nettype none
`include "interval_timer_pair_map.svh"

module interval_timer_pair (
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_slow_osc,
    input  wire logic        i_io_clk_tick,
    input  wire logic        i_timer_base_clock,
    input  wire logic        i_external_clock_in_a,
    input  wire logic        i_external_clock_in_b,
    input  wire logic        i_watchdog_enable_bit,
    input  wire logic        i_global_irq_enable,
    input  wire logic [1:0]  i_vector_taken,
    output logic             o_first_interval_out,
    output logic             o_sensor_strobe_clock,
    output logic             o_second_interval_out,
    output logic             o_motion_sense_run,
    output logic [1:0]       o_vector_request,
    output logic             o_irq
);

    interval_timer_pair_pkg::ctrl_a_t ctrl_a;
    interval_timer_pair_pkg::ctrl_b_t ctrl_b;
    logic [1:0]  flags;
    logic [1:0]  irq_mask;
    logic [1:0]  restart_cnt;
    logic [19:0] osc_cnt;
    logic [11:0] div_cnt;
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic [2:0]  last_level;

    // pin synchronisers: slow osc, ext a, ext b
    wire  [2:0]  pin_in = {i_external_clock_in_b, i_external_clock_in_a,
                           i_slow_osc};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_ref_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    sync_a[g]     <= 1'b0;
                    sync_b[g]     <= 1'b0;
                    last_level[g] <= 1'b0;
                end else begin
                    sync_a[g]     <= pin_in[g];
                    sync_b[g]     <= sync_a[g];
                    last_level[g] <= sync_b[g];
                end
            end
        end
    endgenerate

    // rising edges of the synchronised pins
    wire [2:0] pin_rise = sync_b & ~last_level;
    wire       osc_tick = pin_rise[0];

    // bus decode
    wire setup_ph  = i_psel & ~i_penable;
    wire wr_done   = i_psel & i_penable & o_pready & i_pwrite;
    wire hit_a     = i_paddr == `ADDR_CTRL_A;
    wire hit_f     = i_paddr == `ADDR_FLAGS;
    wire hit_b     = i_paddr == `ADDR_CTRL_B;
    wire hit_m     = i_paddr == `ADDR_IRQ_MASK;
    wire mapped    = hit_a | hit_f | hit_b | hit_m;
    wire wr_a      = wr_done & hit_a;
    wire wr_f      = wr_done & hit_f;
    wire wr_b      = wr_done & hit_b;
    wire wr_m      = wr_done & hit_m;

    wire restart_go = wr_a & i_pwdata[4] & ~i_watchdog_enable_bit;

    logic [19:0] mask_a;
    always_comb begin
        unique case (ctrl_a.interval_prescale_select)
            3'h0: mask_a = 20'h0_0007;
            3'h1: mask_a = 20'h0_001F;
            3'h2: mask_a = 20'h0_007F;
            3'h3: mask_a = 20'h0_03FF;
            3'h4: mask_a = 20'h0_0FFF;
            3'h5: mask_a = 20'h0_7FFF;
            3'h6: mask_a = 20'h3_FFFF;
            3'h7: mask_a = 20'hF_FFFF;
        endcase
    end

    logic [19:0] mask_s;
    logic        sense_on;
    always_comb begin
        sense_on = 1'b1;
        unique case (ctrl_a.sensor_prescale_select)
            3'h1: mask_s = 20'h0_7FFF;
            3'h2: mask_s = 20'h0_FFFF;
            3'h3: mask_s = 20'h1_FFFF;
            3'h4: mask_s = 20'h3_FFFF;
            3'h5: mask_s = 20'h7_FFFF;
            3'h6: mask_s = 20'h0_001F;
            default: begin
                mask_s   = 20'h0_0000;
                sense_on = 1'b0;
            end
        endcase
    end

    wire pulse_a = osc_tick & ((osc_cnt & mask_a) == mask_a);
    wire pulse_s = osc_tick & sense_on & ((osc_cnt & mask_s) == mask_s);

    logic src_tick;
    always_comb begin
        unique case (ctrl_b.divider_clock_select)
            3'h1:    src_tick = o_first_interval_out;
            3'h2:    src_tick = i_io_clk_tick;
            3'h3:    src_tick = i_timer_base_clock;
            3'h4:    src_tick = pin_rise[1];
            3'h5:    src_tick = pin_rise[2];
            default: src_tick = 1'b0;
        endcase
    end

    logic [11:0] mask_b;
    always_comb begin
        unique case (ctrl_b.divider_ratio_select)
            3'h0: mask_b = 12'h001;
            3'h1: mask_b = 12'h003;
            3'h2: mask_b = 12'h007;
            3'h3: mask_b = 12'h00F;
            3'h4: mask_b = 12'h01F;
            3'h5: mask_b = 12'h0FF;
            3'h6: mask_b = 12'h3FF;
            3'h7: mask_b = 12'hFFF;
        endcase
    end

    wire pulse_b = src_tick & ((div_cnt & mask_b) == mask_b);

    wire [1:0] flag_set = {o_second_interval_out, o_first_interval_out};
    wire [1:0] flag_clr = (wr_f ? i_pwdata[1:0] : 2'h0) | i_vector_taken;

    // read mux, unused bits zero
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit_a) begin
            rd_byte = ctrl_a;
        end else if (hit_f) begin
            rd_byte = {6'h00, flags};
        end else if (hit_b) begin
            rd_byte = ctrl_b;
        end else if (hit_m) begin
            rd_byte = {6'h00, irq_mask};
        end
    end

    // apb answer: one access cycle, data latched in setup
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= setup_ph;
            o_pslverr <= setup_ph & ~mapped;
            if (setup_ph) begin
                o_prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // control a, restart bit self-clears
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_a      <= `RST_CTRL_A;
            restart_cnt <= 2'h0;
        end else if (wr_a) begin
            ctrl_a      <= i_pwdata[7:0];
            restart_cnt <= 2'h0;
        end else if (ctrl_a.prescale_restart) begin
            restart_cnt <= restart_cnt + 2'h1;
            if (restart_cnt == `RESTART_HOLD) begin
                ctrl_a.prescale_restart <= 1'b0;
            end
        end
    end

    // control b, reserved bit forced low
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_b <= `RST_CTRL_B;
        end else if (wr_b) begin
            ctrl_b          <= i_pwdata[7:0];
            ctrl_b.reserved <= 1'b0;
        end
    end

    // oscillator cycle counter
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            osc_cnt <= 20'h0_0000;
        end else if (restart_go) begin
            osc_cnt <= 20'h0_0000;
        end else if (osc_tick) begin
            osc_cnt <= osc_cnt + 20'h0_0001;
        end
    end

    // 12-bit divider counter
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_cnt <= 12'h000;
        end else if (src_tick) begin
            div_cnt <= div_cnt + 12'h001;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_first_interval_out  <= 1'b0;
            o_sensor_strobe_clock <= 1'b0;
            o_second_interval_out <= 1'b0;
            o_motion_sense_run    <= 1'b0;
        end else begin
            o_first_interval_out  <= pulse_a;
            o_sensor_strobe_clock <= pulse_s;
            o_second_interval_out <= pulse_b;
            o_motion_sense_run    <= sense_on;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flags <= `RST_FLAGS;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    // interrupt mask register
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_mask <= `RST_IRQ_MASK;
        end else if (wr_m) begin
            irq_mask <= i_pwdata[1:0];
        end
    end

    wire [1:0] ie = {ctrl_b.second_interval_irq_enable,
                     ctrl_a.first_interval_irq_enable};
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_vector_request <= 2'h0;
            o_irq            <= 1'b0;
        end else begin
            o_vector_request <= flags & ie & {2{i_global_irq_enable}};
            o_irq            <= |(flags & irq_mask);
        end
    end

endmodule : interval_timer_pair
`default_nettype wire

// ===== shared/interval_timer_pair_map.svh
// Operation
// - sensor select: 001-101 give 32K..512K cycles, 110 gives 32, else off
// - restart bit restarts prescaler, self-clears four clocks after write
// - restart acts only while the watchdog is disabled
// - first timer flag requests its vector when enabled and global enable set
// - interval select 000-111 gives 8,32,128,1K,4K,32K,256K,1024K cycles
// - flag register bits 7..2 read as zero
// - each second timer pulse sets flag bit 1
// - each first timer pulse sets flag bit 0
// - flags clear on vector taken or by writing one
// - second timer is a 12-bit divider on a selectable clock
// - second timer output serves as prescaler clock downstream
// - clock select 000 none, 001-101 sources, 110/111 reserved
// - divider select gives 2,4,8,16,32,256,1K,4K
// - second flag requests its vector when bit 7 and global enable set
// - control b bit 6 reads zero, writes ignored
// - watchdog enable bit high means enabled, gating the restart
`ifndef INTERVAL_TIMER_PAIR_MAP_SVH
`define INTERVAL_TIMER_PAIR_MAP_SVH

// register byte offsets
`define ADDR_CTRL_A       8'h00
`define ADDR_FLAGS        8'h04
`define ADDR_CTRL_B       8'h08
`define ADDR_IRQ_MASK     8'h0C

// field positions
`define FLAG_FIRST        0
`define FLAG_SECOND       1
`define CTRL_B_RSV_BIT    6

// reset values
`define RST_CTRL_A        8'h00
`define RST_CTRL_B        8'h00
`define RST_FLAGS         2'h0
`define RST_IRQ_MASK      2'h0

// restart bit stays set for this many clocks plus one
`define RESTART_HOLD      2'h3

`endif

// ===== shared/interval_timer_pair_pkg.sv
package interval_timer_pair_pkg;

    typedef struct packed {
        logic [2:0] sensor_prescale_select;
        logic       prescale_restart;
        logic       first_interval_irq_enable;
        logic [2:0] interval_prescale_select;
    } ctrl_a_t;

    typedef struct packed {
        logic       second_interval_irq_enable;
        logic       reserved;
        logic [2:0] divider_clock_select;
        logic [2:0] divider_ratio_select;
    } ctrl_b_t;

endpackage : interval_timer_pair_pkg

// ===== testbench/interval_timer_pair_checker.sv
`timescale 1ns/10ps
`default_nettype none
module interval_timer_pair_checker (
    input wire logic        i_ref_clk,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_global_irq_enable,
    input wire logic [1:0]  i_vector_taken,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_first_interval_out,
    input wire logic        o_second_interval_out,
    input wire logic [1:0]  o_vector_request
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);
    // bus answer timing
    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    a_rdata_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    // prescaler pulses last one cycle
    a_first_pulse_single: assert property (
        o_first_interval_out |=> !o_first_interval_out)
        else $error("first pulse too long");
    a_second_pulse_single: assert property (
        o_second_interval_out |=> !o_second_interval_out)
        else $error("second pulse too long");
    // vector gating and clearing
    a_vector_needs_global: assert property (
        !i_global_irq_enable |=> o_vector_request == 2'h0)
        else $error("vector without global enable");
    a_vector_taken_clears: assert property (
        i_vector_taken[1] && !o_second_interval_out
        |=> ##1 !o_vector_request[1])
        else $error("vector stays after being taken");
endmodule : interval_timer_pair_checker
bind interval_timer_pair interval_timer_pair_checker
    i_interval_timer_pair_checker (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_global_irq_enable(i_global_irq_enable),
    .i_vector_taken(i_vector_taken), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_first_interval_out(o_first_interval_out),
    .o_second_interval_out(o_second_interval_out),
    .o_vector_request(o_vector_request));
`default_nettype wire

// ===== testbench/interval_timer_pair_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "interval_timer_pair_map.svh"
module interval_timer_pair_tb_top;
    typedef struct packed {
        logic       wr;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] q;
        logic       e;
    } row_t;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        osc = 1'b0;
    logic        watchdog_enable_bit = 1'b0;
    logic        gie = 1'b0;
    logic [1:0]  vt = 2'h0;
    logic [31:0] prdata, rq, g;
    logic        pready, re, mrun, irq, rerr;
    logic [2:0]  pulses;
    logic [1:0]  vec;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          oedge = 0;
    int          n;
    logic [31:0] per [4] = '{32'h8, 32'h20, 32'h80, 32'h400};
    row_t        rows [10] = '{
        {1'b0, `ADDR_CTRL_A, 8'h00, 8'h00, 1'b0},
        {1'b0, `ADDR_CTRL_B, 8'h00, 8'h00, 1'b0},
        {1'b1, `ADDR_CTRL_A, 8'hEB, 8'h00, 1'b0},
        {1'b0, `ADDR_CTRL_A, 8'h00, 8'hEB, 1'b0},
        {1'b1, `ADDR_CTRL_B, 8'hFF, 8'h00, 1'b0},
        {1'b0, `ADDR_CTRL_B, 8'h00, 8'hBF, 1'b0},
        {1'b1, `ADDR_IRQ_MASK, 8'hFF, 8'h00, 1'b0},
        {1'b0, `ADDR_IRQ_MASK, 8'h00, 8'h03, 1'b0},
        {1'b1, 8'h10, 8'h55, 8'h00, 1'b1},
        {1'b0, 8'h10, 8'h00, 8'h00, 1'b1}};

    interval_timer_pair i_interval_timer_pair (
        .i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(re),
        .i_slow_osc(osc), .i_io_clk_tick(1'b1), .i_timer_base_clock(1'b0),
        .i_external_clock_in_a(1'b0), .i_external_clock_in_b(1'b0),
        .i_watchdog_enable_bit(watchdog_enable_bit), .i_global_irq_enable(gie),
        .i_vector_taken(vt), .o_first_interval_out(pulses[0]),
        .o_sensor_strobe_clock(pulses[1]),
        .o_second_interval_out(pulses[2]), .o_motion_sense_run(mrun),
        .o_vector_request(vec), .o_irq(irq));

    always #10 clk = ~clk;

    // slow oscillator at one eighth of the clock, edge count, timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) begin
            osc <= ~osc;
            oedge <= oedge + (osc ? 0 : 1);
        end
        if (cyc == 60000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] x, y);
        n_compared++;
        if (y !== x) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", nm, x, y);
        end
    endtask : chk

    // one bus transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= 32'(d);
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rq = prdata;
        rerr = re; // error flag stands only in the access cycle
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    // distance between two pulses, in osc edges or clocks
    task automatic gap(input int w);
        int o;
        do @(posedge clk); while (pulses[w] !== 1'b1);
        o = (w == 2) ? cyc : oedge;
        do @(posedge clk); while (pulses[w] !== 1'b1);
        g = 32'(((w == 2) ? cyc : oedge) - o);
    endtask : gap

    task automatic report_and_stop();
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, int'(rows[i].d));
            if (!rows[i].wr) chk("rdata", 32'(rows[i].q), rq);
            chk("pslverr", 32'(rows[i].e), 32'(rerr));
        end
        apb(1'b0, `ADDR_FLAGS, 0);
        chk("flags_hi", 32'h0, rq & 32'hFFFF_FFFC);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `ADDR_CTRL_A, s);
            gap(0);
            chk("interval", per[s], g);
        end
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `ADDR_CTRL_A, c << 5);
            repeat (3) @(posedge clk);
            chk("sense_run", 32'(c != 0 && c != 7), 32'(mrun));
        end
        apb(1'b1, `ADDR_CTRL_A, 'hC0);
        gap(1);
        chk("sensor", 32'h20, g);
        for (int r = 0; r < 5; r++) begin
            apb(1'b1, `ADDR_CTRL_B, 'h10 + r);
            gap(2);
            chk("divide", 32'(2 << r), g);
        end
        for (int c = 0; c < 7; c += 6) begin
            apb(1'b1, `ADDR_CTRL_B, c << 3);
            repeat (2) @(posedge clk);
            n = 0;
            repeat (40) @(posedge clk) n += int'(pulses[2]);
            chk("no_clock", 32'h0, 32'(n));
        end
        // flags, vectors and interrupt output
        gie <= 1'b1;
        apb(1'b1, `ADDR_CTRL_A, 0);
        repeat (80) @(posedge clk);
        chk("vec_off", 32'h0, 32'(vec));
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, `ADDR_CTRL_A, 'h0F);
        repeat (3) @(posedge clk);
        chk("vec_first", 32'h1, 32'(vec));
        apb(1'b1, `ADDR_FLAGS, 1);
        apb(1'b0, `ADDR_FLAGS, 0);
        chk("flags", 32'h2, rq);
        apb(1'b1, `ADDR_CTRL_B, 'h80);
        repeat (3) @(posedge clk);
        chk("vec_second", 32'h2, 32'(vec));
        vt <= 2'h2;
        @(posedge clk);
        vt <= 2'h0;
        repeat (3) @(posedge clk);
        chk("vec_taken", 32'h0, 32'(vec));
        apb(1'b1, `ADDR_CTRL_B, 'h90);
        apb(1'b1, `ADDR_CTRL_B, 'h80);
        gie <= 1'b0;
        repeat (3) @(posedge clk);
        chk("vec_global", 32'h0, 32'(vec));
        chk("irq_second", 32'h1, 32'(irq));
        apb(1'b1, `ADDR_IRQ_MASK, 0);
        repeat (3) @(posedge clk);
        chk("irq_masked", 32'h0, 32'(irq));
        // restart bit self clears, watchdog off and on
        for (int w = 0; w < 2; w++) begin
            watchdog_enable_bit <= w[0];
            apb(1'b1, `ADDR_CTRL_A, 'h1F);
            apb(1'b0, `ADDR_CTRL_A, 0);
            chk("restart_on", 32'h1F, rq);
            repeat (4) @(posedge clk);
            apb(1'b0, `ADDR_CTRL_A, 0);
            chk("restart_off", 32'h0F, rq);
        end
        // reset in mid-run
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq_rst", 32'h0, 32'(irq));
        nrst <= 1'b1;
        @(posedge clk);
        apb(1'b0, `ADDR_CTRL_A, 0);
        chk("ctrl_a_rst", 32'h0, rq);
        report_and_stop();
    end
endmodule : interval_timer_pair_tb_top
`default_nettype wire
